// >>> design/accel_ctl_pkg.sv
/*
 * Shared constants and types of the accelerometer power, self-check and
 * tap configuration block.
 * Assumes a 25 MHz system clock and a word-wide AHB-Lite register bus.
 */
package accel_ctl_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_MOTION_DETECT   = 8'h27;
    localparam logic [7:0] IDX_POWER_CONTROL   = 8'h2D;
    localparam logic [7:0] IDX_SELFCHECK       = 8'h2E;
    localparam logic [7:0] IDX_TAP_LEVEL       = 8'h2F;
    localparam logic [7:0] IDX_TAP_MAX_WIDTH   = 8'h30;
    localparam logic [7:0] IDX_TAP_HOLDOFF     = 8'h31;
    localparam logic [7:0] IDX_SECOND_TAP_SPAN = 8'h32;
    localparam logic [7:0] IDX_EVENT_STATUS    = 8'h40;
    localparam logic [7:0] IDX_EVENT_MASK      = 8'h41;
    localparam logic [7:0] IDX_TAP_STATE       = 8'h42;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_REG8         = 8'h00;
    localparam int         BIT_SINGLE_TAP   = 0;
    localparam int         BIT_DOUBLE_TAP   = 1;
    localparam int         BIT_SELFCHECK_RUN   = 0;
    localparam int         BIT_SELFCHECK_FORCE = 1;
    localparam logic [1:0] MODE_STANDBY     = 2'h0;
    localparam logic [1:0] MODE_OPERATING_MODE_SELECT     = 2'h2;
    localparam logic [1:0] CHAIN_LINKED     = 2'h1;
    localparam logic [1:0] CHAIN_LOOP       = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 25_000_000;
    localparam int WIDTH_STEP_NS     = 625_000;
    localparam int GAP_STEP_NS       = 1_250_000;
    localparam int WIDTH_STEP_CYC    = int'((64'(WIDTH_STEP_NS) * CLK_HZ) / 1_000_000_000);
    localparam int GAP_STEPS_PER_LSB = GAP_STEP_NS / WIDTH_STEP_NS;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       reserved;
        logic       outside_clock_select;
        logic [1:0] noise_mode;
        logic       motion_wake_mode;
        logic       autosleep;
        logic [1:0] operating_mode_select;
    } power_control_t;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] max_width;
        logic [7:0] holdoff;
        logic [7:0] span;
    } tap_cfg_t;

endpackage

// >>> design/accel_ctl_regs.sv
/*
 * Register bank and tap qualifier: power control, self-check control,
 * tap threshold/width/holdoff/span, with sticky tap events and an interrupt.
 * Assumes one AHB-Lite master, word transfers only, and a magnitude stream
 * from the sensor datapath on the same clock, in 62.5 mg steps.
 */
//
// Operation
// - Power bit 6 selects outside clock
// - Bits 5:4 select noise mode
// - Bit 3 enables motion wake mode
// - Autosleep only when chaining linked or loop
// - Bits 1:0: 00 standby, 10 operating_mode_select
// - Power register at 0x2D, resets zero
// - Self-check run bit0, force bit1, rest zero
// - Tap magnitude compared against unsigned threshold
// - Zero threshold disables all tap detection
// - Tap must stay above no longer than width
// - Holdoff delays second-tap window after tap
// - Zero holdoff disables double tap only
// - Second tap must fall within span
// - Tap registers from 0x2F, read-write, reset zero
`timescale 1ns/1ps
`default_nettype none

module accel_ctl_regs
    import accel_ctl_pkg::*;
#(
    parameter int WIDTH_STEP_CYCLES = WIDTH_STEP_CYC
) (
    // Clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    // AHB-Lite slave
    input  wire logic                         hsel_in,
    input  wire logic [31:0]                  haddr_in,
    input  wire logic [1:0]                   htrans_in,
    input  wire logic                         hwrite_in,
    input  wire logic [2:0]                   hsize_in,
    input  wire logic [31:0]                  hwdata_in,
    input  wire logic                         hready_in,
    output logic      [31:0]                  hrdata_out,
    output logic                              hreadyout_out,
    output logic                              hresp_out,
    // Sensor magnitude stream
    input  wire logic [7:0]                   accel_mag_in,
    input  wire logic                         accel_valid_in,
    // Configuration towards the sensor core
    output accel_ctl_pkg::power_control_t     power_control_out,
    output logic                              autosleep_active_out,
    output logic                              measuring_out,
    output logic                              selfcheck_run_out,
    output logic                              selfcheck_force_out,
    // Events
    output logic                              single_tap_out,
    output logic                              double_tap_out,
    output logic                              irq_out
);
    import accel_ctl_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    power_control_t power_control_r;
    logic [7:0]     selfcheck_r;
    tap_cfg_t       tap_cfg_r;
    logic [1:0]     motion_chaining_mode_r;
    logic [1:0]     event_status_r;
    logic [1:0]     event_mask_r;

    // ------------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------------
    logic        wr_pend_r;
    logic        rd_pend_r;
    logic [7:0]  acc_idx_r;
    logic        acc_hit_r;
    logic [31:0] hrdata_r;
    logic        hreadyout_r;

    wire         bus_take   = hsel_in & htrans_in[1] & hready_in;
    wire         addr_hit   = (haddr_in[31:10] == 22'h0) & (haddr_in[1:0] == 2'h0);
    wire  [7:0]  addr_idx   = haddr_in[9:2];
    wire         wr_commit  = wr_pend_r & acc_hit_r;
    wire  [7:0]  wdata8     = hwdata_in[7:0];

    wire wr_power   = wr_commit & (acc_idx_r == IDX_POWER_CONTROL);
    wire wr_self    = wr_commit & (acc_idx_r == IDX_SELFCHECK);
    wire wr_level   = wr_commit & (acc_idx_r == IDX_TAP_LEVEL);
    wire wr_width   = wr_commit & (acc_idx_r == IDX_TAP_MAX_WIDTH);
    wire wr_holdoff = wr_commit & (acc_idx_r == IDX_TAP_HOLDOFF);
    wire wr_span    = wr_commit & (acc_idx_r == IDX_SECOND_TAP_SPAN);
    wire wr_chain   = wr_commit & (acc_idx_r == IDX_MOTION_DETECT);
    wire wr_status  = wr_commit & (acc_idx_r == IDX_EVENT_STATUS);
    wire wr_mask    = wr_commit & (acc_idx_r == IDX_EVENT_MASK);

    // ------------------------------------------------------------------
    // Tap qualifier
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        TAP_IDLE,
        TAP_FIRST,
        TAP_HOLDOFF,
        TAP_SPAN,
        TAP_SECOND,
        TAP_RELEASE
    } tap_state_t;

    tap_state_t  tap_state_r;
    tap_state_t  tap_state_nxt;
    logic        above_r;
    logic [15:0] step_cnt_r;
    logic [9:0]  steps_r;
    logic        single_set;
    logic        double_set;

    wire         measuring   = (power_control_r.operating_mode_select == MODE_OPERATING_MODE_SELECT);
    wire         tap_enable  = measuring & (tap_cfg_r.level != RST_REG8);
    wire         dbl_enable  = tap_enable & (tap_cfg_r.holdoff != RST_REG8);
    wire         step_tick   = (step_cnt_r == 16'(WIDTH_STEP_CYCLES - 1));
    wire         state_move  = (tap_state_nxt != tap_state_r);
    wire  [9:0]  width_lim   = {2'h0, tap_cfg_r.max_width};
    wire  [9:0]  holdoff_lim = 10'(tap_cfg_r.holdoff * GAP_STEPS_PER_LSB);
    wire  [9:0]  span_lim    = 10'(tap_cfg_r.span * GAP_STEPS_PER_LSB);
    wire         too_long    = (steps_r > width_lim);

    // ------------------------------------------------------------------
    // Readback mux
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        case (acc_idx_r)
            IDX_POWER_CONTROL:   rd_mux = {1'b0, power_control_r[6:0]};
            IDX_SELFCHECK:       rd_mux = selfcheck_r;
            IDX_TAP_LEVEL:       rd_mux = tap_cfg_r.level;
            IDX_TAP_MAX_WIDTH:   rd_mux = tap_cfg_r.max_width;
            IDX_TAP_HOLDOFF:     rd_mux = tap_cfg_r.holdoff;
            IDX_SECOND_TAP_SPAN: rd_mux = tap_cfg_r.span;
            IDX_MOTION_DETECT:   rd_mux = {6'h00, motion_chaining_mode_r};
            IDX_EVENT_STATUS:    rd_mux = {6'h00, event_status_r};
            IDX_EVENT_MASK:      rd_mux = {6'h00, event_mask_r};
            IDX_TAP_STATE:       rd_mux = {5'h00, tap_state_r};
            default:             rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------------
    // Reads take one wait state so that a write in the preceding data
    // phase is already visible in the returned word.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wr_pend_r   <= 1'b0;
            rd_pend_r   <= 1'b0;
            acc_idx_r   <= 8'h00;
            acc_hit_r   <= 1'b0;
            hrdata_r    <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
        end else begin
            if (rd_pend_r) begin
                rd_pend_r   <= 1'b0;
                hrdata_r    <= {24'h00_0000, acc_hit_r ? rd_mux : 8'h00};
                hreadyout_r <= 1'b1;
            end else begin
                wr_pend_r   <= bus_take & hwrite_in;
                rd_pend_r   <= bus_take & ~hwrite_in;
                hreadyout_r <= ~(bus_take & ~hwrite_in);
                if (bus_take) begin
                    acc_idx_r <= addr_idx;
                    acc_hit_r <= addr_hit;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            power_control_r        <= power_control_t'(RST_REG8);
            selfcheck_r            <= RST_REG8;
            tap_cfg_r              <= {4{RST_REG8}};
            motion_chaining_mode_r <= 2'h0;
            event_mask_r           <= 2'h0;
        end else begin
            if (wr_power) begin
                power_control_r <= power_control_t'({1'b0, wdata8[6:0]});
            end
            if (wr_self) begin
                selfcheck_r <= {6'h00, wdata8[1:0]};
            end
            if (wr_level) begin
                tap_cfg_r.level <= wdata8;
            end
            if (wr_width) begin
                tap_cfg_r.max_width <= wdata8;
            end
            if (wr_holdoff) begin
                tap_cfg_r.holdoff <= wdata8;
            end
            if (wr_span) begin
                tap_cfg_r.span <= wdata8;
            end
            if (wr_chain) begin
                motion_chaining_mode_r <= wdata8[1:0];
            end
            if (wr_mask) begin
                event_mask_r <= wdata8[1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Event status: write one to clear, a new event wins
    // ------------------------------------------------------------------
    wire [1:0] status_set = {double_set, single_set};
    wire [1:0] status_clr = wr_status ? wdata8[1:0] : 2'h0;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            event_status_r <= 2'h0;
        end else begin
            event_status_r <= (event_status_r & ~status_clr) | status_set;
        end
    end

    // ------------------------------------------------------------------
    // Tap timing
    // ------------------------------------------------------------------
    // Step timer restarts on every state change so that each interval
    // is measured from its own start, not from a free-running phase.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            above_r     <= 1'b0;
            step_cnt_r  <= 16'h0000;
            steps_r     <= 10'h000;
            tap_state_r <= TAP_IDLE;
        end else begin
            if (accel_valid_in) begin
                above_r <= (accel_mag_in > tap_cfg_r.level);
            end
            tap_state_r <= tap_state_nxt;
            if (state_move || step_tick) begin
                step_cnt_r <= 16'h0000;
            end else begin
                step_cnt_r <= step_cnt_r + 16'h0001;
            end
            if (state_move) begin
                steps_r <= 10'h000;
            end else if (step_tick && steps_r != 10'h3FF) begin
                steps_r <= steps_r + 10'h001;
            end
        end
    end

    always_comb begin
        tap_state_nxt = tap_state_r;
        single_set    = 1'b0;
        double_set    = 1'b0;
        case (tap_state_r)
            TAP_IDLE: begin
                if (tap_enable && above_r) begin
                    tap_state_nxt = TAP_FIRST;
                end
            end
            TAP_FIRST: begin
                if (too_long) begin
                    tap_state_nxt = TAP_RELEASE;
                end else if (!above_r) begin
                    single_set    = 1'b1;
                    tap_state_nxt = dbl_enable ? TAP_HOLDOFF : TAP_IDLE;
                end
            end
            TAP_HOLDOFF: begin
                if (steps_r >= holdoff_lim) begin
                    tap_state_nxt = TAP_SPAN;
                end
            end
            TAP_SPAN: begin
                if (steps_r >= span_lim) begin
                    tap_state_nxt = TAP_IDLE;
                end else if (above_r) begin
                    tap_state_nxt = TAP_SECOND;
                end
            end
            TAP_SECOND: begin
                if (too_long) begin
                    tap_state_nxt = TAP_RELEASE;
                end else if (!above_r) begin
                    single_set    = 1'b1;
                    double_set    = 1'b1;
                    tap_state_nxt = TAP_IDLE;
                end
            end
            TAP_RELEASE: begin
                if (!above_r) begin
                    tap_state_nxt = TAP_IDLE;
                end
            end
            default: begin
                tap_state_nxt = TAP_IDLE;
            end
        endcase
        // Losing tap_enable, or dbl_enable after the first tap, aborts a sequence in flight
        if (!tap_enable) begin
            tap_state_nxt = TAP_IDLE;
            single_set    = 1'b0;
            double_set    = 1'b0;
        end else if (!dbl_enable && (tap_state_r == TAP_HOLDOFF || tap_state_r == TAP_SPAN
                                     || tap_state_r == TAP_SECOND)) begin
            tap_state_nxt = TAP_IDLE;
            double_set    = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    wire chain_ok = (motion_chaining_mode_r == CHAIN_LINKED)
                  | (motion_chaining_mode_r == CHAIN_LOOP);

    logic single_tap_r;
    logic double_tap_r;
    logic irq_r;
    logic autosleep_active_r;
    logic measuring_r;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            single_tap_r       <= 1'b0;
            double_tap_r       <= 1'b0;
            irq_r              <= 1'b0;
            autosleep_active_r <= 1'b0;
            measuring_r        <= 1'b0;
        end else begin
            single_tap_r       <= single_set;
            double_tap_r       <= double_set;
            irq_r              <= |(event_status_r & event_mask_r);
            autosleep_active_r <= power_control_r.autosleep & chain_ok;
            measuring_r        <= measuring;
        end
    end

    assign hrdata_out           = hrdata_r;
    assign hreadyout_out        = hreadyout_r;
    assign hresp_out            = 1'b0;
    assign power_control_out    = power_control_r;
    assign autosleep_active_out = autosleep_active_r;
    assign measuring_out        = measuring_r;
    assign selfcheck_run_out    = selfcheck_r[BIT_SELFCHECK_RUN];
    assign selfcheck_force_out  = selfcheck_r[BIT_SELFCHECK_FORCE];
    assign single_tap_out       = single_tap_r;
    assign double_tap_out       = double_tap_r;
    assign irq_out              = irq_r;

endmodule

`default_nettype wire

// >>> sim/accel_ctl_regs_asserts.sv
/*
 * Concurrent checks on the ports of the power, self-check and tap block.
 * Assumes it is bound to accel_ctl_regs and sees that module's ports only.
 */
`timescale 1ns/1ps
`default_nettype none

module accel_ctl_regs_asserts
    import accel_ctl_pkg::*;
#(
    parameter int WIDTH_STEP_CYCLES = WIDTH_STEP_CYC
) (
    // Clock and reset
    input wire logic                          ref_clk_in,
    input wire logic                          rst_in,
    // Bus
    input wire logic                          hsel_in,
    input wire logic [31:0]                   haddr_in,
    input wire logic [1:0]                    htrans_in,
    input wire logic                          hwrite_in,
    input wire logic [31:0]                   hwdata_in,
    input wire logic                          hready_in,
    input wire logic [31:0]                   hrdata_out,
    input wire logic                          hreadyout_out,
    input wire logic                          hresp_out,
    // Configuration and events
    input wire accel_ctl_pkg::power_control_t power_control_out,
    input wire logic                          autosleep_active_out,
    input wire logic                          measuring_out,
    input wire logic                          selfcheck_run_out,
    input wire logic                          selfcheck_force_out,
    input wire logic                          single_tap_out,
    input wire logic                          double_tap_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    sequence s_rd_addr;
        hsel_in && htrans_in[1] && hready_in && !hwrite_in;
    endsequence
    sequence s_wr_addr;
        hsel_in && htrans_in[1] && hready_in && hwrite_in;
    endsequence
    // Write commits at the data-phase edge, one cycle after the address
    sequence s_wr_to(logic [7:0] idx);
        s_wr_addr ##0 (haddr_in == {22'h0, idx, 2'h0}) ##1 1'b1;
    endsequence

    property p_read_wait;
        s_rd_addr |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    property p_write_nowait;
        s_wr_addr |=> hreadyout_out;
    endproperty
    property p_pwr_write;
        s_wr_to(IDX_POWER_CONTROL) |=> power_control_out == power_control_t'({1'b0, $past(hwdata_in[6:0])});
    endproperty
    property p_sc_write;
        s_wr_to(IDX_SELFCHECK) |=> {selfcheck_force_out, selfcheck_run_out} == $past(hwdata_in[1:0]);
    endproperty
    property p_pwr_rsvd;
        power_control_out.reserved == 1'b0;
    endproperty
    property p_meas;
        measuring_out == ($past(power_control_out.operating_mode_select) == MODE_OPERATING_MODE_SELECT);
    endproperty
    property p_auto;
        autosleep_active_out |-> power_control_out.autosleep || $past(power_control_out.autosleep);
    endproperty
    property p_hi_zero;
        hrdata_out[31:8] == 24'h0 && hresp_out == 1'b0;
    endproperty
    property p_single_pulse;
        single_tap_out |=> !single_tap_out;
    endproperty
    property p_double_pair;
        double_tap_out |-> single_tap_out;
    endproperty
    property p_tap_meas;
        single_tap_out |-> measuring_out || $past(measuring_out);
    endproperty

    a_read_wait:    assert property (p_read_wait) else $error("read wait state wrong");
    a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
    a_pwr_write:    assert property (p_pwr_write) else $error("power write lost");
    a_sc_write:     assert property (p_sc_write) else $error("self-check write lost");
    a_pwr_rsvd:     assert property (p_pwr_rsvd) else $error("power bit 7 set");
    a_meas:         assert property (p_meas) else $error("measuring flag wrong");
    a_auto:         assert property (p_auto) else $error("autosleep without bit");
    a_hi_zero:      assert property (p_hi_zero) else $error("upper read bits set");
    a_single_pulse: assert property (p_single_pulse) else $error("single tap too long");
    a_double_pair:  assert property (p_double_pair) else $error("double without single");
    a_tap_meas:     assert property (p_tap_meas) else $error("tap outside measurement");
endmodule

`default_nettype wire

// >>> sim/accel_ctl_regs_bench.sv
/*
 * Self-checking bench of accel_ctl_regs: registers, interrupt and tap timing.
 * Assumes the package and the checker file are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module accel_ctl_regs_bench;
    import accel_ctl_pkg::*;
    // Short step keeps the tap windows to a few dozen cycles
    localparam int STEP = 4;
    logic        ref_clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0, accel_valid_in = 1'b1;
    logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd_s, rd;
    logic [1:0]  htrans_in = 2'h0;
    logic [2:0]  hsize_in = 3'h2;
    logic [7:0]  accel_mag_in = 8'h00;
    wire logic   hready_in;
    power_control_t power_control_out;
    logic hreadyout_out, hresp_out, autosleep_active_out, measuring_out, selfcheck_run_out;
    logic selfcheck_force_out, single_tap_out, double_tap_out, irq_out, rdy_s;
    int   bad_count = 0, cmp_count = 0, n_s = 0, n_d = 0, exp_s = 0, exp_d = 0;

    assign hready_in = hreadyout_out;
    accel_ctl_regs #(.WIDTH_STEP_CYCLES(STEP)) DUT (.*);

    always #20 ref_clk_in = ~ref_clk_in;
    // Outputs move only on rising edges, so the falling-edge copy is what the next edge samples
    always @(negedge ref_clk_in) begin
        rdy_s <= hreadyout_out;
        rd_s <= hrdata_out;
    end
    always @(posedge ref_clk_in) begin
        if (single_tap_out === 1'b1) n_s <= n_s + 1;
        if (double_tap_out === 1'b1) n_d <= n_d + 1;
    end

    // ------------------------------------------------------------------
    // Bus and stimulus helpers
    // ------------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] wd);
        @(posedge ref_clk_in);
        haddr_in <= {22'h0, idx, 2'h0};
        htrans_in <= 2'h2;
        hwrite_in <= w;
        hsel_in <= 1'b1;
        do @(posedge ref_clk_in); while (rdy_s !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= {24'h0, wd};
        do @(posedge ref_clk_in); while (rdy_s !== 1'b1);
        rd = rd_s;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        bus(i, 1'b1, d);
    endtask
    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        bus(i, 1'b0, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask
    task automatic cfg(input logic [7:0] i, input logic [7:0] d);
        wr(IDX_POWER_CONTROL, 8'h00);
        wr(i, d);
        wr(IDX_POWER_CONTROL, 8'h02);
    endtask
    task automatic tap(input logic [7:0] m, input int n);
        @(posedge ref_clk_in);
        accel_mag_in <= m;
        idle(n);
        accel_mag_in <= 8'h00;
    endtask
    task automatic expect_taps(input int ds, input int dd);
        idle(40);
        exp_s += ds;
        exp_d += dd;
        `CHK(n_s, exp_s)
        `CHK(n_d, exp_d)
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        for (int k = 0; k < 6; k++) rchk(8'(IDX_POWER_CONTROL + k), 8'h00);
        `CHK({power_control_out, irq_out, measuring_out}, 10'h000)
    endtask
    task automatic t_power;
        logic [7:0] v[6] = '{8'h40, 8'h10, 8'h20, 8'h08, 8'h02, 8'hEC};
        foreach (v[k]) begin
            wr(IDX_POWER_CONTROL, v[k]);
            idle(2);
            `CHK(power_control_out, v[k] & 8'h7F)
            `CHK(measuring_out, v[k][1:0] == MODE_OPERATING_MODE_SELECT)
            rchk(IDX_POWER_CONTROL, v[k] & 8'h7F);
        end
        wr(IDX_SELFCHECK, 8'hFF);
        idle(2);
        `CHK({selfcheck_force_out, selfcheck_run_out}, 2'h3)
        rchk(IDX_SELFCHECK, 8'h03);
        wr(IDX_SELFCHECK, 8'h01);
        idle(2);
        `CHK({selfcheck_force_out, selfcheck_run_out}, 2'h1)
    endtask
    task automatic t_regs;
        for (int k = 0; k < 4; k++) wr(8'(IDX_TAP_LEVEL + k), 8'hA5 ^ 8'(k));
        for (int k = 0; k < 4; k++) rchk(8'(IDX_TAP_LEVEL + k), 8'hA5 ^ 8'(k));
        wr(8'h33, 8'hFF);
        rchk(8'h33, 8'h00);
    endtask
    task automatic t_autosleep;
        logic [1:0] c[4] = '{2'h0, CHAIN_LINKED, CHAIN_LOOP, 2'h2};
        wr(IDX_POWER_CONTROL, 8'h04);
        foreach (c[k]) begin
            wr(IDX_MOTION_DETECT, {6'h0, c[k]});
            idle(3);
            `CHK(autosleep_active_out, c[k][0])
        end
    endtask
    task automatic t_taps;
        wr(IDX_TAP_LEVEL, 8'h10);
        wr(IDX_TAP_MAX_WIDTH, 8'h02);
        wr(IDX_TAP_HOLDOFF, 8'h01);
        wr(IDX_SECOND_TAP_SPAN, 8'h02);
        wr(IDX_POWER_CONTROL, 8'h02);
        tap(8'h10, 6);
        expect_taps(0, 0);
        tap(8'h11, 6);
        expect_taps(1, 0);
        tap(8'hFF, 40);
        expect_taps(0, 0);
        tap(8'h40, 6);
        idle(14);
        tap(8'h40, 6);
        expect_taps(2, 1);
        tap(8'h40, 6);
        idle(60);
        tap(8'h40, 6);
        expect_taps(2, 0);
        cfg(IDX_TAP_HOLDOFF, 8'h00);
        tap(8'h40, 6);
        idle(14);
        tap(8'h40, 6);
        expect_taps(2, 0);
        cfg(IDX_TAP_LEVEL, 8'h00);
        tap(8'h40, 6);
        expect_taps(0, 0);
        wr(IDX_POWER_CONTROL, 8'h00);
        wr(IDX_TAP_LEVEL, 8'h10);
        tap(8'h40, 6);
        expect_taps(0, 0);
    endtask
    task automatic t_irq;
        `CHK(irq_out, 1'b0)
        wr(IDX_EVENT_MASK, 8'h01);
        idle(2);
        `CHK(irq_out, 1'b1)
        rchk(IDX_EVENT_STATUS, 8'h03);
        wr(IDX_EVENT_STATUS, 8'h01);
        idle(2);
        `CHK(irq_out, 1'b0)
        rchk(IDX_EVENT_STATUS, 8'h02);
        wr(IDX_EVENT_MASK, 8'h02);
        idle(2);
        `CHK(irq_out, 1'b1)
        wr(IDX_EVENT_STATUS, 8'h02);
        idle(2);
        `CHK(irq_out, 1'b0)
    endtask

    task automatic finish_test;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        idle(8);
        rst_in <= 1'b0;
        t_reset;
        t_power;
        t_regs;
        t_autosleep;
        t_taps;
        t_irq;
        finish_test;
    end
    initial begin
        idle(20000);
        bad_count++;
        finish_test;
    end
endmodule

bind accel_ctl_regs accel_ctl_regs_asserts #(.WIDTH_STEP_CYCLES(WIDTH_STEP_CYCLES)) u_chk (.*);

`default_nettype wire
